// [logic/adc_channel_result_control.sv]
`timescale 1ns/1ps
module adc_channel_result_control
   import adc_select_pkg::*;
#(
   parameter int CONVERSION_CYCLES = CONV_CYCLES
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [2:0] address,
   input wire logic [7:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   output logic [7:0] read_data,
   input wire logic [10:0] sample_value,
   output logic [1:0] reference_select,
   output logic [4:0] channel_select,
   output logic [2:0] pos_input,
   output logic [2:0] neg_input,
   output logic source_differential,
   output logic source_fixed,
   output logic source_valid,
   output logic sample_request,
   output logic conversion_busy,
   output logic irq
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   typedef enum logic [1:0] {IDLE, CONVERT, FINISH} conv_state_t;
   conv_state_t state_reg;
   logic [7:0] select_reg;
   logic [1:0] ref_active_reg;
   logic [4:0] chan_active_reg;
   logic [9:0] result_reg;
   logic [9:0] frozen_reg;
   logic freeze_reg;
   logic [7:0] count_reg;
   logic done_flag_reg;
   logic mask_reg;
   logic [7:0] read_next;
   logic [9:0] code;
   logic [9:0] shown;
   logic [7:0] low_byte;
   logic [7:0] high_byte;
   logic left_align_result;
   logic start;
   logic done;
   source_kind_t kind;

   assign left_align_result = select_reg[ALIGN_BIT];
   assign start = write_strobe && address == ADDR_CONTROL && write_data[CTRL_START_BIT];
   assign done = state_reg == FINISH;

   channel_decode u_decode (
      .channel_select(chan_active_reg),
      .kind(kind),
      .pos_input(pos_input),
      .neg_input(neg_input)
   );

   code_format u_format (
      .differential(kind == SRC_DIFF),
      .sample(sample_value),
      .code(code)
   );

   // ----------------------------------------
   // Selection register
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) select_reg <= SELECT_RESET; // [R04]
      else if (write_strobe && address == ADDR_SELECT) select_reg <= write_data; // [R04]
   end

   // Active selection follows the register only outside a conversion
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ref_active_reg <= REF_EXTERNAL;
         chan_active_reg <= 5'h00;
      end else if (state_reg == IDLE || done) begin
         ref_active_reg <= select_reg[REF_HI:REF_LO]; // [R06]
         chan_active_reg <= select_reg[CHAN_HI:0]; // [R06]
      end
   end

   // ----------------------------------------
   // Conversion sequencer
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg <= IDLE;
         count_reg <= 8'h00;
      end else begin
         case (state_reg)
            IDLE: if (start) begin
               state_reg <= CONVERT;
               count_reg <= 8'h00;
            end
            CONVERT: begin
               count_reg <= count_reg + 8'h01;
               if (count_reg == 8'(CONVERSION_CYCLES - 2)) state_reg <= FINISH;
            end
            FINISH: state_reg <= IDLE;
            default: state_reg <= IDLE;
         endcase
      end
   end

   // Result loads in the same edge that raises the done flag
   always_ff @(posedge clock) begin
      if (!rst_n) result_reg <= 10'h000;
      else if (done) begin
         if (kind == SRC_NONE || ref_active_reg == REF_RESERVED) result_reg <= 10'h000;
         else result_reg <= code; // [R03]
      end
   end

   // ----------------------------------------
   // Result byte lock
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         freeze_reg <= 1'b0;
         frozen_reg <= 10'h000;
      end else if (read_strobe && address == ADDR_RESULT_LOW) begin
         freeze_reg <= 1'b1; // [R13]
         frozen_reg <= freeze_reg ? frozen_reg : result_reg; // [R13]
      end else if (read_strobe && address == ADDR_RESULT_HIGH) begin
         freeze_reg <= 1'b0; // [R13]
      end
   end

   assign shown = freeze_reg ? frozen_reg : result_reg;

   always_comb begin
      if (left_align_result) begin // [R07] [R08]
         high_byte = shown[9:2]; // [R12]
         low_byte = {shown[1:0], 6'h00}; // [R12]
      end else begin
         high_byte = {6'h00, shown[9:8]}; // [R12]
         low_byte = shown[7:0]; // [R12]
      end
   end

   // ----------------------------------------
   // Interrupt status and mask
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) done_flag_reg <= 1'b0;
      else if (done) done_flag_reg <= 1'b1; // [R03]
      else if (write_strobe && address == ADDR_IRQ_STATUS && write_data[0]) done_flag_reg <= 1'b0;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) mask_reg <= 1'b0;
      else if (write_strobe && address == ADDR_IRQ_MASK) mask_reg <= write_data[0];
   end

   assign irq = done_flag_reg && mask_reg;

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_comb begin
      read_next = 8'h00;
      case (address)
         ADDR_SELECT: read_next = select_reg;
         ADDR_CONTROL: begin
            read_next[CTRL_BUSY_BIT] = state_reg != IDLE;
            read_next[CTRL_INVALID_BIT] = kind == SRC_NONE;
         end
         ADDR_RESULT_LOW: read_next = low_byte;
         ADDR_RESULT_HIGH: read_next = high_byte;
         ADDR_IRQ_STATUS: read_next = {7'h00, done_flag_reg};
         ADDR_IRQ_MASK: read_next = {7'h00, mask_reg};
         default: read_next = 8'h00;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) read_data <= 8'h00;
      else if (read_strobe) read_data <= read_next;
      else read_data <= 8'h00;
   end

   // ----------------------------------------
   // Analog front-end controls
   // ----------------------------------------
   assign reference_select = ref_active_reg; // [R05]
   assign channel_select = chan_active_reg;
   assign source_differential = kind == SRC_DIFF;
   assign source_fixed = kind == SRC_FIXED;
   assign source_valid = kind != SRC_NONE;
   assign sample_request = state_reg == CONVERT; // [R11]
   assign conversion_busy = state_reg != IDLE;
endmodule : adc_channel_result_control

// [shared/adc_select_pkg.sv]
// How it works
// R01: Single-ended code is unsigned, 0 to 0x3ff
// R02: Differential code is two's complement, clamped
// R03: Result bytes loaded before done flag sets; logic loads result and done flag on the same edge
// R04: Selection register: reference, align, channel; reset zero
// R05: Reference codes: external, supply, reserved, internal
// R06: Selection changes wait until conversion completes
// R07: Alignment bit picks left or right placement
// R08: Alignment change shows at once
// R09: Codes 0-7 single-ended, 8-15 no input
// R10: Differential pairs, bandgap and ground codes
// R11: Outside logic keeps analog pins quiet converting
// R12: Byte layout for right and left alignment
// R13: Low byte read freezes bytes until high read
package adc_select_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [2:0] ADDR_SELECT = 3'h0;
   localparam logic [2:0] ADDR_CONTROL = 3'h1;
   localparam logic [2:0] ADDR_RESULT_LOW = 3'h2;
   localparam logic [2:0] ADDR_RESULT_HIGH = 3'h3;
   localparam logic [2:0] ADDR_IRQ_STATUS = 3'h4;
   localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;
   localparam logic [7:0] SELECT_RESET = 8'h00;
   localparam int REF_HI = 7;
   localparam int REF_LO = 6;
   localparam int ALIGN_BIT = 5;
   localparam int CHAN_HI = 4;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_BUSY_BIT = 1;
   localparam int CTRL_INVALID_BIT = 2;
   // ----------------------------------------
   // Reference and channel codes
   // ----------------------------------------
   localparam logic [1:0] REF_EXTERNAL = 2'h0;
   localparam logic [1:0] REF_SUPPLY = 2'h1;
   localparam logic [1:0] REF_RESERVED = 2'h2;
   localparam logic [1:0] REF_INTERNAL = 2'h3;
   localparam logic [1:0] CHAN_GROUP_SINGLE = 2'h0;
   localparam logic [1:0] CHAN_GROUP_NONE = 2'h1;
   localparam logic [1:0] CHAN_GROUP_NEG1 = 2'h2;
   localparam logic [1:0] CHAN_GROUP_NEG2 = 2'h3;
   localparam logic [2:0] CHAN_BANDGAP = 3'h6;
   localparam logic [2:0] CHAN_GROUND = 3'h7;
   localparam logic [2:0] NEG_INPUT_1 = 3'h1;
   localparam logic [2:0] NEG_INPUT_2 = 3'h2;
   // ----------------------------------------
   // Code limits and timing
   // ----------------------------------------
   localparam logic [9:0] SINGLE_MAX = 10'h3ff;
   localparam logic [9:0] DIFF_MAX = 10'h1ff;
   localparam logic [9:0] DIFF_MIN = 10'h200;
   localparam int CONV_CYCLES = 13;
   typedef enum logic [1:0] {SRC_NONE, SRC_SINGLE, SRC_DIFF, SRC_FIXED} source_kind_t;
endpackage : adc_select_pkg

// [logic/channel_decode.sv]
`timescale 1ns/1ps
module channel_decode
   import adc_select_pkg::*;
(
   input wire logic [4:0] channel_select,
   output source_kind_t kind,
   output logic [2:0] pos_input,
   output logic [2:0] neg_input
);
   always_comb begin
      kind = SRC_NONE;
      pos_input = channel_select[2:0];
      neg_input = 3'h0;
      case (channel_select[4:3])
         CHAN_GROUP_SINGLE: kind = SRC_SINGLE; // [R09]
         CHAN_GROUP_NONE: kind = SRC_NONE; // [R09]
         CHAN_GROUP_NEG1: begin
            kind = SRC_DIFF; // [R10]
            neg_input = NEG_INPUT_1;
         end
         CHAN_GROUP_NEG2: begin
            if (channel_select[2:0] == CHAN_BANDGAP || channel_select[2:0] == CHAN_GROUND) begin
               kind = SRC_FIXED; // [R10]
            end else begin
               kind = SRC_DIFF; // [R10]
               neg_input = NEG_INPUT_2;
            end
         end
         default: kind = SRC_NONE;
      endcase
   end
endmodule : channel_decode

// [logic/code_format.sv]
`timescale 1ns/1ps
module code_format
   import adc_select_pkg::*;
(
   input wire logic differential,
   input wire logic [10:0] sample,
   output logic [9:0] code
);
   // sample: single-ended unsigned 0..2047, low 10 bits give 0..1023 and values above 1023 clamp to 1023;
   // differential: signed 11-bit value already scaled by 512.
   always_comb begin
      if (differential) begin
         if (!sample[10] && sample[9]) code = DIFF_MAX; // [R02]
         else if (sample[10] && !sample[9]) code = DIFF_MIN; // [R02]
         else code = sample[9:0]; // [R02]
      end else begin
         code = sample[10] ? SINGLE_MAX : sample[9:0]; // [R01]
      end
   end
endmodule : code_format

// [bench/adc_select_sva.sv]
`timescale 1ns/1ps
module adc_select_sva
   import adc_select_pkg::*;
#(parameter int CONVERSION_CYCLES = CONV_CYCLES)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [2:0] address,
   input wire logic [7:0] write_data,
   input wire logic write_strobe,
   input wire logic [1:0] reference_select,
   input wire logic [4:0] channel_select,
   input wire logic [2:0] pos_input,
   input wire logic [2:0] neg_input,
   input wire logic source_differential,
   input wire logic source_fixed,
   input wire logic source_valid,
   input wire logic sample_request,
   input wire logic conversion_busy
);
   // ----------------------------------------
   // Busy length counter
   // ----------------------------------------
   int busy_count;
   always_ff @(posedge clock) begin
      if (!rst_n) busy_count <= 0;
      else busy_count <= conversion_busy ? busy_count + 1 : 0;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_busy_length: assert property ($fell(conversion_busy) |-> busy_count == CONVERSION_CYCLES)
      else $error("conversion length wrong");
   a_start_busy: assert property (write_strobe && address == ADDR_CONTROL && write_data[CTRL_START_BIT] &&
      !conversion_busy |=> conversion_busy && sample_request) else $error("start not taken");
   a_sel_locked: assert property (sample_request && $past(sample_request) |->
      $stable(channel_select) && $stable(reference_select)) else $error("selection moved while converting");
   a_decode_single: assert property (channel_select[4:3] == 2'b00 |-> source_valid &&
      !source_differential && pos_input == channel_select[2:0]) else $error("single decode wrong");
   a_decode_none: assert property (channel_select[4:3] == 2'b01 |-> !source_valid)
      else $error("invalid code decoded as input");
   a_decode_neg1: assert property (channel_select[4:3] == 2'b10 |-> source_differential &&
      neg_input == NEG_INPUT_1 && pos_input == channel_select[2:0]) else $error("first pair decode wrong");
   a_decode_neg2: assert property (channel_select[4:3] == 2'b11 && channel_select[2:1] != 2'b11 |->
      source_differential && neg_input == NEG_INPUT_2 && pos_input == channel_select[2:0]) else $error("pair decode");
   a_decode_fixed: assert property (channel_select[4:1] == 4'hf |-> source_fixed && !source_differential)
      else $error("fixed source decode wrong");
endmodule : adc_select_sva
bind adc_channel_result_control adc_select_sva #(.CONVERSION_CYCLES(CONVERSION_CYCLES)) sva_i (.clock, .rst_n,
   .address, .write_data, .write_strobe, .reference_select, .channel_select, .pos_input, .neg_input,
   .source_differential, .source_fixed, .source_valid, .sample_request, .conversion_busy);

// [bench/analog_source_model.sv]
`timescale 1ns/1ps
module analog_source_model (
   input wire logic clock,
   input wire logic [10:0] level,
   input wire logic [2:0] pos_input,
   input wire logic [2:0] neg_input,
   input wire logic source_differential,
   input wire logic source_fixed,
   input wire logic source_valid,
   output logic [10:0] sample_value
);
   logic [10:0] idle_pattern = 11'h000;
   always @(posedge clock) idle_pattern <= idle_pattern + 11'h2a5;
   // Unselected inputs show a moving pattern, never a held value
   always_comb begin
      if (!source_valid || source_fixed) sample_value = idle_pattern;
      else if (source_differential) sample_value = level + {8'h00, pos_input} - {8'h00, neg_input};
      else sample_value = level ^ {8'h00, pos_input};
   end
endmodule : analog_source_model

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
   import adc_select_pkg::*;
   logic clock, rst_n, write_strobe, read_strobe, source_differential, source_fixed, source_valid;
   logic sample_request, conversion_busy, irq;
   logic [2:0] address, pos_input, neg_input;
   logic [7:0] write_data, read_data, sel, junk, mask;
   logic [10:0] sample_value, level;
   logic [1:0] reference_select;
   logic [4:0] channel_select;
   logic [9:0] code;
   logic [7:0] exp_q[$];
   logic pend = 1'b0;
   int fail_count = 0;
   int tests_run = 0;
   int seed = 56;
   int n;
   adc_channel_result_control #(.CONVERSION_CYCLES(4)) DUT (.clock, .rst_n, .address, .write_data, .write_strobe,
      .read_strobe, .read_data, .sample_value, .reference_select, .channel_select, .pos_input, .neg_input,
      .source_differential, .source_fixed, .source_valid, .sample_request, .conversion_busy, .irq);
   analog_source_model source_i (.clock, .level, .pos_input, .neg_input, .source_differential, .source_fixed,
      .source_valid, .sample_value);
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // ----------------------------------------
   // Bus tasks and read monitor
   // ----------------------------------------
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      address <= a;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge clock);
      write_strobe <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clock);
      address <= a;
      read_strobe <= 1'b1;
      exp_q.push_back(e);
      @(posedge clock);
      read_strobe <= 1'b0;
   endtask : rd
   always @(posedge clock) begin
      if (pend) begin
         tests_run++;
         if (read_data !== exp_q[0]) begin
            fail_count++;
            $display("wrong value at %0t: read %h expected %h", $time, read_data, exp_q[0]);
         end
         void'(exp_q.pop_front());
      end
      pend <= read_strobe;
   end
   task automatic chk(input logic got, input logic e, input string what);
      tests_run++;
      if (got !== e) begin
         fail_count++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask : chk
   task automatic wait_done();
      n = 0;
      #1;
      while (conversion_busy !== 1'b0 && n < 50) begin
         @(posedge clock);
         #1;
         n++;
      end
      if (n == 50) begin
         fail_count++;
         $display("wrong value at %0t: conversion never ended", $time);
      end
   endtask : wait_done
   function automatic logic [9:0] expect_code(input logic [7:0] s, input logic [10:0] l);
      logic [10:0] v;
      if (s[7:6] == REF_RESERVED || s[4:3] == 2'b01) return 10'h000;
      v = l ^ {8'h00, s[2:0]};
      if (!s[4]) return v[10] ? SINGLE_MAX : v[9:0];
      v = l + {8'h00, s[2:0]} - (s[3] ? 11'h002 : 11'h001);
      if (!v[10] && v[9]) return DIFF_MAX;
      if (v[10] && !v[9]) return DIFF_MIN;
      return v[9:0];
   endfunction : expect_code
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   initial begin
      #100000;
      fail_count++;
      finish_test();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      address = 3'h0;
      write_data = 8'h00;
      write_strobe = 1'b0;
      read_strobe = 1'b0;
      level = 11'h000;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      rd(ADDR_SELECT, SELECT_RESET);
      rd(ADDR_IRQ_STATUS, 8'h00);
      rd(3'h7, 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 12; i++) begin
         sel = 8'($random(seed));
         sel[4:0] = sel[4:0] % 5'd30;
         junk = 8'($random(seed));
         level <= 11'($random(seed));
         mask = {7'h00, i[0]};
         wr(ADDR_IRQ_MASK, mask);
         wr(ADDR_SELECT, sel);
         rd(ADDR_SELECT, sel);
         chk(channel_select == sel[4:0] && reference_select == sel[7:6], 1'b1, "idle selection");
         wr(ADDR_CONTROL, 8'h01);
         wr(ADDR_SELECT, junk);
         wait_done();
         chk(channel_select == junk[4:0] && reference_select == junk[7:6], 1'b1, "selection after done");
         code = expect_code(sel, level);
         rd(ADDR_RESULT_LOW, junk[5] ? {code[1:0], 6'h00} : code[7:0]);
         rd(ADDR_RESULT_HIGH, junk[5] ? code[9:2] : {6'h00, code[9:8]});
         chk(irq, mask[0], "irq level");
         rd(ADDR_IRQ_STATUS, 8'h01);
         wr(ADDR_IRQ_STATUS, 8'h01);
         #1;
         chk(irq, 1'b0, "irq after clear");
      end
      $display("test conversions done");
      wr(ADDR_SELECT, 8'h40);
      level <= 11'h155;
      wr(ADDR_CONTROL, 8'h01);
      rd(ADDR_CONTROL, 8'h02);
      wait_done();
      rd(ADDR_RESULT_LOW, 8'h55);
      level <= 11'h2aa;
      wr(ADDR_CONTROL, 8'h01);
      wait_done();
      rd(ADDR_RESULT_HIGH, 8'h01);
      repeat (3) @(posedge clock);
      $display("test result freeze done");
      wr(ADDR_SELECT, 8'h08);
      rd(ADDR_CONTROL, 8'h04);
      wr(ADDR_SELECT, 8'h1f);
      rd(ADDR_CONTROL, 8'h00);
      chk(source_fixed, 1'b1, "ground code not fixed");
      repeat (3) @(posedge clock);
      $display("test channel status done");
      finish_test();
   end
endmodule : testbench
